// ### rtl/bil_pkg.sv
package bil_pkg;
  // Timing base and derived cycle counts.
  localparam int unsigned CLK_HZ       = 40_000_000;
  localparam int unsigned RST_MIN_NS   = 15_000;
  localparam int unsigned RST_CYC      = (RST_MIN_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int unsigned LINK_EN_NS   = 2_000;
  localparam int unsigned LINK_CYC     = (LINK_EN_NS * (CLK_HZ / 1_000_000)) / 1000;
  // Serial clock ratios are kept relative to the nominal core rate.
  localparam int unsigned CORE_HZ      = 400_000_000;
  localparam int unsigned QSPI_HZ      = 50_000_000;
  localparam int unsigned SPI_HZ       = 2_500_000;
  localparam int unsigned QSPI_HALF    = CORE_HZ / (2 * QSPI_HZ);
  localparam int unsigned SPI_HALF     = CORE_HZ / (2 * SPI_HZ);
  localparam int unsigned LINK_TX_HALF = 4;
  // Image format constants.
  localparam logic [31:0] CRC_POLY     = 32'hedb88320;
  localparam logic [31:0] CRC_INIT     = 32'hffffffff;
  localparam logic [31:0] CRC_SKIP     = 32'h0d15ab1e;
  localparam logic [31:0] ACK_NULL     = 32'h0000ff02;
  localparam logic [7:0]  READ_CMD     = 8'h03;
  localparam logic [7:0]  END_TOKEN    = 8'h01;
  localparam logic [5:0]  CMD_BITS     = 6'h20;
  localparam int unsigned SEC_BOOT_BIT = 5;
  localparam int unsigned RAM_AW       = 18;
  localparam logic [RAM_AW-1:0] RAM_BASE = 18'h00000;
  localparam logic [15:0] OTP_BASE     = 16'h0000;

  typedef enum logic [2:0] {
    SRC_QSPI  = 3'h0,
    SRC_SPI   = 3'h1,
    SRC_SLAVE = 3'h2,
    SRC_LINK  = 3'h3,
    SRC_OTP   = 3'h4
  } bil_src_t;

  typedef enum logic [3:0] {
    ST_RST   = 4'h0,
    ST_LWAIT = 4'h1,
    ST_ACK   = 4'h2,
    ST_LEN   = 4'h3,
    ST_PROG  = 4'h4,
    ST_CRC   = 4'h5,
    ST_END   = 4'h6,
    ST_SEND  = 4'h7,
    ST_DONE  = 4'h8,
    ST_FAIL  = 4'h9
  } bil_st_t;

  // Serial flash master pins; enables are active low.
  typedef struct packed {
    logic       ss_n;
    logic       ss_oe_n;
    logic       sclk;
    logic       sclk_oe_n;
    logic       mosi;
    logic       mosi_oe_n;
    logic [3:0] quad_data_lines;
    logic [3:0] quad_oe_n;
  } bil_spi_out_t;

  localparam bil_spi_out_t SPI_IDLE = '{1'b1, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 4'h0, 4'hf};

  typedef struct packed {
    logic              we;
    logic [RAM_AW-1:0] addr;
    logic [7:0]        data;
  } bil_ram_wr_t;

  // Inputs arriving from outside the clock domain.
  typedef struct packed {
    logic [2:0] strap;
    logic       miso;
    logic [3:0] quad;
    logic       s_ss_n;
    logic       s_sclk;
    logic       s_mosi;
    logic       l_clk;
    logic       l_dat;
  } bil_pin_in_t;
endpackage

// ### rtl/bil_loader.sv
`timescale 1ns/1ps
module bil_loader (
  input  wire logic                  clock,
  input  wire logic                  arst_n,
  input  wire logic                  boot_strap_bit0,
  input  wire logic                  boot_strap_bit1,
  input  wire logic                  boot_strap_bit2,
  input  wire logic [31:0]           sec_word,
  input  wire logic [31:0]           otp_rdata,
  input  wire logic                  miso_in,
  input  wire logic [3:0]            quad_in,
  input  wire logic                  slv_ss_n,
  input  wire logic                  slv_sclk,
  input  wire logic                  slv_mosi,
  input  wire logic                  link_clk_in,
  input  wire logic                  link_rx_in,
  output wire logic                  gpio_pulldown_en,
  output wire logic                  link_pulldown_en,
  output wire logic                  link_enable,
  output wire logic [1:0]            link_group,
  output wire logic                  link_tx_clk,
  output wire logic                  link_tx_data,
  output wire bil_pkg::bil_spi_out_t spi_pins,
  output wire logic                  otp_rd,
  output wire logic [15:0]           otp_addr,
  output wire bil_pkg::bil_ram_wr_t  ram_wr,
  output wire logic                  boot_done,
  output wire logic                  boot_fail,
  output wire logic [bil_pkg::RAM_AW-1:0] exec_addr
);
  import bil_pkg::*;

  typedef struct packed {
    bil_st_t      st;
    logic [9:0]   tmr;
    bil_pin_in_t  s1;
    bil_pin_in_t  s2;
    logic         sclk3;
    logic         lclk3;
    bil_src_t     src;
    logic         gpd;
    logic         lpd;
    logic         len;
    logic [1:0]   lgrp;
    logic [31:0]  word;
    logic [1:0]   bcnt;
    logic [33:0]  rem;
    logic [31:0]  crc;
    logic [31:0]  ack;
    logic         ok;
    logic [RAM_AW-1:0] waddr;
    bil_ram_wr_t  ram;
    logic         done;
    logic         fail;
    logic         mon;
    logic         mrx;
    logic [7:0]   mdiv;
    logic [5:0]   mcnt;
    logic [31:0]  mtx;
    logic [1:0]   rise;
    bil_spi_out_t spi;
    logic [8:0]   rsr;
    logic [3:0]   rcnt;
    logic         rbusy;
    logic         ord;
    logic         opend;
    logic [15:0]  oaddr;
    logic [31:0]  oword;
    logic [2:0]   oleft;
    logic         tbusy;
    logic         tclk;
    logic         tdat;
    logic [9:0]   tsr;
    logic [3:0]   tcnt;
    logic [2:0]   tdiv;
  } bil_state_t;

  bil_state_t  r;
  bil_state_t  n;
  bil_pin_in_t pin_in;

  assign pin_in = {boot_strap_bit2, boot_strap_bit1, boot_strap_bit0, miso_in, quad_in,
                   slv_ss_n, slv_sclk, slv_mosi, link_clk_in, link_rx_in};

  // One CRC step over a byte, reflected form.
  function automatic logic [31:0] crc_byte(input logic [31:0] c, input logic [7:0] d);
    logic [31:0] x;
    x = c ^ {24'h000000, d};
    for (int i = 0; i < 8; i++) begin
      x = x[0] ? ((x >> 1) ^ CRC_POLY) : (x >> 1);
    end
    return x;
  endfunction

  // strap decode; the security bit overrides the straps.
  function automatic bil_src_t pick_src(input logic sec, input logic [2:0] s);
    if (sec) begin
      return SRC_OTP;
    end
    if (s[2]) begin
      return SRC_LINK;
    end
    if (s[1]) begin
      return SRC_SLAVE;
    end
    return s[0] ? SRC_SPI : SRC_QSPI;
  endfunction

  // Next-state logic: byte sources, parser and link transmitter.
  always_comb begin
    logic       bv;
    logic       bc;
    logic       quad;
    logic       fin_ok;
    logic [7:0] bb;
    logic [7:0] half;
    logic [7:0] nb;
    logic [8:0] nl;
    logic [31:0] nw;
    bv = 1'b0;
    bc = 1'b0;
    bb = 8'h00;
    fin_ok = 1'b0;
    n = r;
    n.s1 = pin_in;
    n.s2 = r.s1;
    n.sclk3 = r.s2.s_sclk;
    n.lclk3 = r.s2.l_clk;
    n.ram.we = 1'b0;
    n.ord = 1'b0;
    quad = (r.src == SRC_QSPI);
    half = quad ? QSPI_HALF[7:0] : SPI_HALF[7:0];
    n.rise = {r.rise[0], 1'b0};
    if (r.mon) begin
      if (r.mdiv == half - 8'h01) begin
        n.mdiv = 8'h00;
        n.spi.sclk = ~r.spi.sclk;
        if (!r.spi.sclk) begin
          n.rise[0] = 1'b1;
        end else if (!r.mrx) begin
          n.mtx = {r.mtx[30:0], 1'b0};
          n.mcnt = r.mcnt + 6'h01;
          if (r.mcnt == CMD_BITS - 6'h01) begin
            n.mrx = 1'b1;
            n.spi.quad_oe_n = 4'hf;
          end
        end
      end else begin
        n.mdiv = r.mdiv + 8'h01;
      end
    end
    n.spi.mosi = n.mtx[31];
    n.spi.quad_data_lines[0] = n.mtx[31];
    nb = quad ? {r.s2.quad, r.rsr[7:4]} : {r.s2.miso, r.rsr[7:1]};
    if (r.mon && r.mrx && r.rise[1]) begin
      n.rsr[7:0] = nb;
      n.rcnt = r.rcnt + 4'h1;
      if (r.rcnt == (quad ? 4'h1 : 4'h7)) begin
        n.rcnt = 4'h0;
        bv = 1'b1;
        bb = nb;
      end
    end
    if (r.src == SRC_SLAVE && r.st != ST_RST) begin
      if (r.s2.s_ss_n) begin
        n.rcnt = 4'h0;
      end else if (r.s2.s_sclk && !r.sclk3) begin
        n.rsr[7:0] = {r.s2.s_mosi, r.rsr[7:1]};
        n.rcnt = r.rcnt + 4'h1;
        if (r.rcnt == 4'h7) begin
          n.rcnt = 4'h0;
          bv = 1'b1;
          bb = {r.s2.s_mosi, r.rsr[7:1]};
        end
      end
    end
    // Link tokens: start bit, control flag, then eight data bits.
    nl = {r.s2.l_dat, r.rsr[8:1]};
    if (r.src == SRC_LINK && r.len && r.s2.l_clk && !r.lclk3) begin
      if (!r.rbusy) begin
        n.rbusy = r.s2.l_dat;
        n.rcnt = 4'h0;
      end else begin
        n.rsr = nl;
        n.rcnt = r.rcnt + 4'h1;
        if (r.rcnt == 4'h8) begin
          n.rbusy = 1'b0;
          bv = 1'b1;
          bc = nl[0];
          bb = nl[8:1];
        end
      end
    end
    if (r.src == SRC_OTP && r.st inside {ST_LEN, ST_PROG, ST_CRC}) begin
      if (r.ord) begin
        n.opend = 1'b1;
        n.oaddr = r.oaddr + 16'h0001;
      end else if (r.opend) begin
        n.opend = 1'b0;
        n.oword = otp_rdata;
        n.oleft = 3'h4;
      end else if (r.oleft != 3'h0) begin
        bv = 1'b1;
        bb = r.oword[7:0];
        n.oword = {8'h00, r.oword[31:8]};
        n.oleft = r.oleft - 3'h1;
      end else begin
        n.ord = 1'b1;
      end
    end
    // Link transmitter, data changes while the clock is low.
    if (r.tbusy) begin
      if (r.tdiv == LINK_TX_HALF[2:0] - 3'h1) begin
        n.tdiv = 3'h0;
        n.tclk = ~r.tclk;
        if (r.tclk) begin
          n.tsr = {1'b0, r.tsr[9:1]};
          n.tcnt = r.tcnt + 4'h1;
          n.tbusy = (r.tcnt != 4'h9);
        end
      end else begin
        n.tdiv = r.tdiv + 3'h1;
      end
    end
    n.tdat = n.tbusy & n.tsr[0];
    nw = {bb, r.word[31:8]};
    unique case (r.st)
      ST_RST: begin
        n.tmr = r.tmr + 10'h001;
        if (r.tmr == RST_CYC[9:0] - 10'h001) begin
          n.tmr = 10'h000;
          n.gpd = 1'b0;
          n.src = pick_src(sec_word[SEC_BOOT_BIT], r.s2.strap);
          n.lgrp = r.s2.strap[1:0];
          n.st = ST_LEN;
          unique case (n.src)
            SRC_QSPI, SRC_SPI: begin
              n.mon = 1'b1;
              n.mtx = {READ_CMD, 24'h000000};
              n.spi.ss_n = 1'b0;
              n.spi.ss_oe_n = 1'b0;
              n.spi.sclk_oe_n = 1'b0;
              n.spi.mosi_oe_n = (n.src == SRC_QSPI);
              n.spi.quad_oe_n = (n.src == SRC_QSPI) ? 4'h0 : 4'hf;
            end
            SRC_LINK: n.st = ST_LWAIT;
            SRC_SLAVE, SRC_OTP: n.st = ST_LEN;
          endcase
        end
      end
      ST_LWAIT: begin
        n.tmr = r.tmr + 10'h001;
        if (r.tmr == LINK_CYC[9:0] - 10'h001) begin
          n.len = 1'b1;
          n.lpd = 1'b0;
          n.st = ST_ACK;
        end
      end
      ST_ACK, ST_LEN, ST_PROG, ST_CRC: begin
        if (bv && bc) begin
          n.st = ST_FAIL;
        end else if (bv) begin
          n.word = nw;
          n.bcnt = r.bcnt + 2'h1;
          if (r.st != ST_CRC && r.st != ST_ACK) begin
            n.crc = crc_byte(r.crc, bb);
          end
          if (r.st == ST_ACK && r.bcnt == 2'h3) begin
            n.ack = nw;
            n.st = ST_LEN;
          end
          if (r.st == ST_LEN && r.bcnt == 2'h3) begin
            n.rem = {nw, 2'b00};
            n.st = (nw == 32'h0) ? ST_CRC : ST_PROG;
          end
          if (r.st == ST_PROG) begin
            n.ram = '{we: 1'b1, addr: r.waddr, data: bb};
            n.waddr = r.waddr + 1'b1;
            n.rem = r.rem - 34'h1;
            n.st = (r.rem == 34'h1) ? ST_CRC : ST_PROG;
          end
          if (r.st == ST_CRC && r.bcnt == 2'h3) begin
            fin_ok = (nw == CRC_SKIP) || (nw == ~r.crc);
            n.ok = fin_ok;
            n.st = (r.src == SRC_LINK) ? ST_END : (fin_ok ? ST_DONE : ST_FAIL);
          end
        end
      end
      ST_END: begin
        if (bv && bc && bb == END_TOKEN) begin
          if (r.ack != ACK_NULL) begin
            n.tbusy = 1'b1;
            n.tsr = {END_TOKEN, 2'b11};
            n.tcnt = 4'h0;
            n.st = ST_SEND;
          end else begin
            n.st = r.ok ? ST_DONE : ST_FAIL;
          end
        end
      end
      ST_SEND: begin
        if (!r.tbusy) begin
          n.st = r.ok ? ST_DONE : ST_FAIL;
        end
      end
      ST_DONE, ST_FAIL: n.st = r.st;
      default: n.st = ST_FAIL;
    endcase
    n.done = (n.st == ST_DONE);
    n.fail = (n.st == ST_FAIL);
    // The serial clock ends its high phase no later than the edge on which select rises, so it idles low.
    if ((n.done || n.fail) && !n.spi.sclk) begin
      n.mon = 1'b0;
      n.spi.ss_n = 1'b1;
    end
  end

  // State register.
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      r <= '0;
      r.gpd <= 1'b1;
      r.lpd <= 1'b1;
      r.spi <= SPI_IDLE;
      r.crc <= CRC_INIT;
      r.waddr <= RAM_BASE;
      r.oaddr <= OTP_BASE;
    end else begin
      r <= n;
    end
  end

  assign gpio_pulldown_en = r.gpd;
  assign link_pulldown_en = r.lpd;
  assign link_enable      = r.len;
  assign link_group       = r.lgrp;
  assign link_tx_clk      = r.tclk;
  assign link_tx_data     = r.tdat;
  assign spi_pins         = r.spi;
  assign otp_rd           = r.ord;
  assign otp_addr         = r.oaddr;
  assign ram_wr           = r.ram;
  assign boot_done        = r.done;
  assign boot_fail        = r.fail;
  assign exec_addr        = RAM_BASE;

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!arst_n);

  property p_pd_rst;
    r.st == ST_RST |-> gpio_pulldown_en && link_pulldown_en;
  endproperty
  a_pd_rst: assert property (p_pd_rst) else $error("pull-down off during reset delay");

  property p_rst_len;
    ($past(r.st) == ST_RST && r.st != ST_RST) |-> $past(r.tmr) == RST_CYC[9:0] - 10'h001;
  endproperty
  a_rst_len: assert property (p_rst_len) else $error("reset delay wrong length");

  property p_sec;
    (r.st == ST_RST && r.tmr == RST_CYC[9:0] - 10'h001 && sec_word[SEC_BOOT_BIT])
      |=> r.src == SRC_OTP && r.st == ST_LEN;
  endproperty
  a_sec: assert property (p_sec) else $error("secure bit did not force memory boot");

  property p_strap;
    (r.st == ST_RST && r.tmr == RST_CYC[9:0] - 10'h001 && !sec_word[SEC_BOOT_BIT] && r.s2.strap == 3'b001)
      |=> r.src == SRC_SPI && !spi_pins.mosi_oe_n && !spi_pins.ss_n;
  endproperty
  a_strap: assert property (p_strap) else $error("strap 001 did not start single master");

  property p_qclk;
    ($rose(spi_pins.sclk) && r.src == SRC_QSPI) |-> spi_pins.sclk[*4] ##1 !spi_pins.sclk;
  endproperty
  a_qclk: assert property (p_qclk) else $error("quad clock high time wrong");

  property p_link_en;
    (r.st == ST_LWAIT && r.tmr == LINK_CYC[9:0] - 10'h001) |=> link_enable && !link_pulldown_en && !link_tx_data;
  endproperty
  a_link_en: assert property (p_link_en) else $error("links not enabled on time");

  property p_base;
    $rose(r.st == ST_PROG) |-> r.waddr == RAM_BASE ##1 (r.waddr == RAM_BASE || ram_wr.we);
  endproperty
  a_base: assert property (p_base) else $error("program not placed at RAM base");

  property p_ack;
    $rose(r.tbusy) |-> r.ack != ACK_NULL && $past(r.st) == ST_END;
  endproperty
  a_ack: assert property (p_ack) else $error("end token sent to null channel");

  property p_jump;
    boot_done |-> r.ok && !boot_fail && (spi_pins.mosi_oe_n || r.src == SRC_SPI);
  endproperty
  a_jump: assert property (p_jump) else $error("jump taken without valid image");

  property p_slave;
    r.src == SRC_SLAVE |-> spi_pins.ss_oe_n && spi_pins.sclk_oe_n && (&spi_pins.quad_oe_n);
  endproperty
  a_slave: assert property (p_slave) else $error("slave boot drives master pins");
endmodule

// ### tb/bil_flash_model.sv
`timescale 1ns/1ps
// Serial flash that returns a 16-byte image after a 32-bit read command.
module bil_flash_model (
  input  wire logic       clock,
  input  wire logic       quad_mode,
  input  wire logic       ss_n,
  input  wire logic       sclk,
  input  wire logic       mosi,
  input  wire logic [3:0] qd,
  output logic            miso_o,
  output logic [3:0]      quad_o
);
  logic [7:0]  mem [0:15];
  logic [31:0] cmd;
  logic [7:0]  rises;
  logic [7:0]  pos;
  logic        sclk_q;

  initial begin
    miso_o = 1'h0;
    quad_o = 4'h0;
    rises = 8'h00;
    pos = 8'h00;
    sclk_q = 1'h0;
    cmd = 32'h0;
  end

  // Command bits are taken on the clock rise, image data moves on the fall.
  always @(posedge clock) begin
    sclk_q <= sclk;
    if (ss_n) begin
      rises <= 8'h00;
      pos <= 8'h00;
    end else if (sclk && !sclk_q && rises < 8'h20) begin
      rises <= rises + 8'h01;
      cmd <= {cmd[30:0], quad_mode ? qd[0] : mosi};
    end else if (!sclk && sclk_q && rises == 8'h20) begin
      pos <= pos + 8'h01;
      quad_o <= pos[0] ? mem[pos[4:1]][7:4] : mem[pos[4:1]][3:0];
      miso_o <= mem[pos[6:3]][pos[2:0]];
    end
    // Undriven lines show a changing pattern, never a stale value.
    if (ss_n || rises < 8'h20) begin
      miso_o <= ~miso_o;
      quad_o <= ~quad_o;
    end
  end
endmodule

// ### tb/tb_boot_image_loader.sv
`timescale 1ns/1ps
module tb_boot_image_loader;
  import bil_pkg::*;
  typedef struct {
    logic [2:0]  strap;
    logic        sec;
    int          kind;
    logic [31:0] ack;
    logic        exp_done;
    logic        exp_fail;
    logic [6:0]  exp_oe;
  } bil_row_t;

  logic              clock, arst_n, quad_mode, f_miso, slv_ss_n, slv_sclk, slv_mosi;
  logic              link_clk_in, link_rx_in, gpio_pd, link_pd, link_enable, tx_clk, tx_data;
  logic              otp_rd, boot_done, boot_fail, txc_q, addr_bad, otp_seen;
  logic [2:0]        strap;
  logic [1:0]        link_group;
  logic [3:0]        f_quad;
  logic [9:0]        tx_bits;
  logic [15:0]       otp_addr, otp_first;
  logic [31:0]       sec_word, otp_rdata;
  logic [RAM_AW-1:0] exec_addr;
  logic [7:0]        img [0:15];
  logic [7:0]        ram [0:7];
  bil_spi_out_t      spi_pins;
  bil_ram_wr_t       ram_wr;
  bil_row_t          rows [0:9];
  int                err_total, check_count, wr_cnt, tx_cnt;

  bil_loader uut (.clock(clock), .arst_n(arst_n), .boot_strap_bit0(strap[0]), .boot_strap_bit1(strap[1]),
    .boot_strap_bit2(strap[2]), .sec_word(sec_word), .otp_rdata(otp_rdata), .miso_in(f_miso),
    .quad_in(f_quad), .slv_ss_n(slv_ss_n), .slv_sclk(slv_sclk), .slv_mosi(slv_mosi),
    .link_clk_in(link_clk_in), .link_rx_in(link_rx_in), .gpio_pulldown_en(gpio_pd),
    .link_pulldown_en(link_pd), .link_enable(link_enable), .link_group(link_group),
    .link_tx_clk(tx_clk), .link_tx_data(tx_data), .spi_pins(spi_pins), .otp_rd(otp_rd),
    .otp_addr(otp_addr), .ram_wr(ram_wr), .boot_done(boot_done), .boot_fail(boot_fail),
    .exec_addr(exec_addr));

  bil_flash_model flash (.clock(clock), .quad_mode(quad_mode), .ss_n(spi_pins.ss_n), .sclk(spi_pins.sclk),
    .mosi(spi_pins.mosi), .qd(spi_pins.quad_data_lines), .miso_o(f_miso), .quad_o(f_quad));

  initial begin
    clock = 1'h0;
    forever #12.5 clock = ~clock;
  end

  // Collect link transmit bits and RAM writes.
  always @(posedge clock) begin
    txc_q <= tx_clk;
    if (tx_clk && !txc_q) begin
      tx_bits <= {tx_data, tx_bits[9:1]};
      tx_cnt <= tx_cnt + 1;
    end
    if (ram_wr.we) begin
      if (ram_wr.addr !== RAM_AW'(wr_cnt)) addr_bad <= 1'h1;
      if (wr_cnt < 8) ram[wr_cnt] <= ram_wr.data;
      wr_cnt <= wr_cnt + 1;
    end
  end

  // One-time memory answers on the falling clock edge within each read pulse.
  always @(negedge clock) begin
    if (otp_rd === 1'h1) begin
      otp_rdata <= {img[{otp_addr[1:0], 2'h3}], img[{otp_addr[1:0], 2'h2}],
                    img[{otp_addr[1:0], 2'h1}], img[{otp_addr[1:0], 2'h0}]};
      if (!otp_seen) otp_first <= otp_addr;
      otp_seen <= 1'h1;
    end
  end

  task automatic test_done();
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic chk(string nm, logic [31:0] exp, logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask

  function automatic logic [31:0] crc_of(int n);
    logic [31:0] c;
    c = CRC_INIT;
    for (int i = 0; i < n; i++) begin
      c = c ^ {24'h0, img[i]};
      for (int b = 0; b < 8; b++) c = c[0] ? (c >> 1) ^ CRC_POLY : c >> 1;
    end
    return ~c;
  endfunction

  // Image with a two-word program: length LSB first, program, then check word.
  task automatic build(int kind);
    logic [31:0] c;
    for (int i = 0; i < 12; i++) img[i] = (i == 0) ? 8'h02 : (i < 4) ? 8'h00 : 8'h3c ^ (8'(i) * 8'h1b);
    c = crc_of(12);
    if (kind == 1) c = CRC_SKIP;
    if (kind == 2) c = c ^ 32'h1;
    for (int i = 0; i < 4; i++) img[12+i] = c[8*i +: 8];
    for (int i = 0; i < 16; i++) flash.mem[i] = img[i];
  endtask

  task automatic do_reset();
    int n;
    arst_n = 1'h0;
    wr_cnt = 0;
    tx_cnt = 0;
    addr_bad = 1'h0;
    otp_seen = 1'h0;
    repeat (6) @(negedge clock);
    chk("reset pulls", 3'h7, {gpio_pd, link_pd, spi_pins.ss_n});
    arst_n = 1'h1;
    n = 0;
    while (gpio_pd !== 1'h0 && n < 7000) begin
      @(negedge clock);
      n++;
    end
    chk("start delay ok", 1, n >= 15000 / 25 && n <= 150000 / 25);
  endtask

  task automatic slave_send(logic cpol);
    slv_sclk = cpol;
    repeat (8) @(negedge clock);
    slv_ss_n = 1'h0;
    repeat (8) @(negedge clock);
    for (int i = 0; i < 128; i++) begin
      slv_sclk = 1'h0;
      slv_mosi = img[i/8][i%8];
      repeat (8) @(negedge clock);
      slv_sclk = 1'h1;
      repeat (8) @(negedge clock);
    end
    slv_sclk = cpol;
    repeat (8) @(negedge clock);
    slv_ss_n = 1'h1;
    slv_mosi = ~slv_mosi;
  endtask

  task automatic tok(logic ctrl, logic [7:0] d);
    logic [9:0] b;
    b = {d, ctrl, 1'h1};
    for (int i = 0; i < 10; i++) begin
      link_rx_in = b[i];
      repeat (4) @(negedge clock);
      link_clk_in = 1'h1;
      repeat (4) @(negedge clock);
      link_clk_in = 1'h0;
    end
    link_rx_in = 1'h0;
    @(negedge clock);
  endtask

  task automatic link_boot(logic [31:0] ack, int nimg);
    int n;
    n = 3;
    while (link_enable !== 1'h1 && n < 500) begin
      @(negedge clock);
      n++;
    end
    chk("link enable delay", 1, n >= LINK_CYC - 2 && n <= LINK_CYC + 2);
    chk("link idle", {3'h0, strap[1:0]}, {link_pd, tx_clk, tx_data, link_group});
    for (int i = 0; i < 4; i++) tok(1'h0, ack[8*i +: 8]);
    for (int i = 0; i < nimg; i++) tok(1'h0, img[i]);
    tok(1'h1, END_TOKEN);
  endtask

  task automatic wait_end();
    int n;
    n = 0;
    while (boot_done !== 1'h1 && boot_fail !== 1'h1 && n < 30000) begin
      @(negedge clock);
      n++;
    end
    repeat (2) @(negedge clock);
  endtask

  task automatic run_row(bil_row_t r);
    strap = r.strap;
    sec_word = {26'h0, r.sec, 5'h0};
    quad_mode = (r.strap == 3'h0);
    build(r.kind);
    do_reset();
    repeat (3) @(negedge clock);
    chk("pin enables", r.exp_oe, {spi_pins.ss_oe_n, spi_pins.sclk_oe_n, spi_pins.mosi_oe_n,
        spi_pins.quad_oe_n});
    if (!r.sec && r.strap[2:1] == 2'h1) slave_send(r.strap[0]);
    if (!r.sec && r.strap[2]) link_boot(r.ack, 16);
    wait_end();
    chk("done fail", {r.exp_done, r.exp_fail}, {boot_done, boot_fail});
    chk("ram writes", 8, wr_cnt);
    chk("ram order", 0, addr_bad);
    for (int i = 0; i < 8; i++) chk("ram byte", img[4+i], ram[i]);
    if (r.exp_done) chk("exec addr", 0, exec_addr);
    if (r.sec) chk("otp start", OTP_BASE, otp_first);
    if (!r.sec && r.strap[2:1] == 2'h0) chk("read command", {READ_CMD, 24'h0}, flash.cmd);
    if (!r.sec && r.strap[2]) begin
      chk("ack bits", (r.ack != ACK_NULL) ? 10 : 0, tx_cnt);
      if (r.ack != ACK_NULL) chk("ack token", {END_TOKEN, 2'h3}, tx_bits);
    end
  endtask

  initial begin
    #(100_000 * 25);
    err_total++;
    $display("watchdog expired");
    test_done();
  end

  // Ordinary cases, then a mid-run reset and a stray control token.
  initial begin
    arst_n = 1'h0;
    strap = 3'h0;
    sec_word = 32'h0;
    otp_rdata = 32'h0;
    quad_mode = 1'h0;
    slv_ss_n = 1'h1;
    slv_sclk = 1'h0;
    slv_mosi = 1'h0;
    link_clk_in = 1'h0;
    link_rx_in = 1'h0;
    err_total = 0;
    check_count = 0;
    rows = '{'{3'h0, 1'h0, 0, 32'h0, 1'h1, 1'h0, 7'h10}, '{3'h1, 1'h0, 1, 32'h0, 1'h1, 1'h0, 7'h0f},
             '{3'h2, 1'h0, 0, 32'h0, 1'h1, 1'h0, 7'h7f}, '{3'h3, 1'h0, 2, 32'h0, 1'h0, 1'h1, 7'h7f},
             '{3'h4, 1'h0, 0, 32'h102, 1'h1, 1'h0, 7'h7f}, '{3'h5, 1'h0, 1, ACK_NULL, 1'h1, 1'h0, 7'h7f},
             '{3'h6, 1'h0, 2, 32'h102, 1'h0, 1'h1, 7'h7f}, '{3'h7, 1'h0, 0, ACK_NULL, 1'h1, 1'h0, 7'h7f},
             '{3'h0, 1'h1, 0, 32'h0, 1'h1, 1'h0, 7'h7f}, '{3'h3, 1'h1, 2, 32'h0, 1'h0, 1'h1, 7'h7f}};
    for (int i = 0; i < 10; i++) run_row(rows[i]);
    strap = 3'h0;
    sec_word = 32'h0;
    quad_mode = 1'h1;
    do_reset();
    repeat (100) @(negedge clock);
    arst_n = 1'h0;
    #1;
    chk("mid reset pins", 8'hff, {gpio_pd, spi_pins.ss_n, spi_pins.ss_oe_n, spi_pins.sclk_oe_n,
        spi_pins.quad_oe_n});
    strap = 3'h4;
    build(0);
    do_reset();
    repeat (3) @(negedge clock);
    link_boot(32'h102, 6);
    wait_end();
    chk("stray control", 2'h1, {boot_done, boot_fail});
    test_done();
  end
endmodule
